// [hdl/adc_sequencer.sv]
// Purpose: two-pass subranging conversion sequencer with master/slave election
// Assumes: peer, trigger and filter signals are asynchronous pins
// Notes:   both pass words come in on the one pass_word port; dither left to caller
//
// Overview of operation
// - flag missed sample if request arrives while holding
// - only one controller sequences at a time
// - channel-two board sequences both when present
// - master sends finish and switch select to slave
// - channel-one board is master when alone
// - role line inverts pulled-up input, low means master
// - role line enables shared-signal buffers on master only
// - master drives clear and switch select jointly
// - slave uses received switch select as timing
// - local convert starts converter; master's starts both
// - master drives track-and-hold to both boards
// - select high first pass; low/clear high reference
// - request holds; controller releases when digitized
// - reset reference routed between the passes
// - result sent serially only after filter request
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer #(
    parameter int unsigned PASS_CNT  = adc_seq_pkg::PASS_CYCLES,
    parameter int unsigned CLEAR_CNT = adc_seq_pkg::CLEAR_CYCLES
) (
    input  wire logic                                clk,
    input  wire logic                                rst_b,
    input  wire logic                                convert_request,
    input  wire logic                                role_line_in,
    input  wire logic                                peer_done_in,
    input  wire logic                                peer_pass_select_in,
    input  wire logic                                filter_data_request_n,
    input  wire logic                                serial_config_data,
    input  wire logic [7:0]                          pass_word,
    output logic                                     role_line_out,
    output logic                                     shared_drive_oe_n,
    output logic                                     sample_hold_ctrl,
    output logic                                     pass_select,
    output logic                                     converter_clear_select,
    output logic                                     local_convert_cmd,
    output logic                                     done_out,
    output logic                                     missed_sample_flag,
    output logic                                     result_data,
    output logic                                     result_valid,
    output logic                                     config_bit
);
    import adc_seq_pkg::*;

    logic                        req_s;
    logic                        req_d_reg;
    logic                        role_s;
    logic                        pdone_s;
    logic                        psel_s;
    logic                        psel_d_reg;
    logic                        dreq_n_s;
    logic                        cfg_s;
    logic                        is_master;
    logic                        req_rise;
    logic                        go_second;
    seq_state_t                  state_reg;
    logic [CNT_W-1:0]            cnt_reg;
    logic [RESULT_BITS-1:0]      result_reg;
    logic [BIT_CNT_W-1:0]        bit_reg;

    // every single-bit control pin passes two flip-flops before use; pass_word is used directly
    adc_sync2 u_sync_req  (.clk(clk), .rst_b(rst_b), .async_in(convert_request),
                           .sync_out(req_s));
    adc_sync2 u_sync_role (.clk(clk), .rst_b(rst_b), .async_in(role_line_in),
                           .sync_out(role_s));
    adc_sync2 u_sync_done (.clk(clk), .rst_b(rst_b), .async_in(peer_done_in),
                           .sync_out(pdone_s));
    adc_sync2 u_sync_psel (.clk(clk), .rst_b(rst_b), .async_in(peer_pass_select_in),
                           .sync_out(psel_s));
    adc_sync2 u_sync_dreq (.clk(clk), .rst_b(rst_b), .async_in(filter_data_request_n),
                           .sync_out(dreq_n_s));
    adc_sync2 u_sync_cfg  (.clk(clk), .rst_b(rst_b), .async_in(serial_config_data),
                           .sync_out(cfg_s));

    // pulled-up input used uninverted; a high own line means master
    assign is_master = role_s;
    assign req_rise  = req_s & ~req_d_reg;
    // slave paces its second pass on the master's select falling
    assign go_second = is_master ? (cnt_reg == '0) : (psel_d_reg & ~psel_s);

    // edge history registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_d_reg  <= 1'b0;
            psel_d_reg <= 1'b0;
        end else begin
            req_d_reg  <= req_s;
            psel_d_reg <= psel_s;
        end
    end

    // role and buffer enable outputs; only the master drives shared lines
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            role_line_out     <= 1'b1;
            shared_drive_oe_n <= 1'b1;
            config_bit        <= 1'b0;
        end else begin
            role_line_out     <= ~role_s;
            shared_drive_oe_n <= ~is_master;
            config_bit        <= cfg_s;
        end
    end

    // missed sample: request while still holding; held until next request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            missed_sample_flag <= 1'b0;
        end else if (req_rise) begin
            missed_sample_flag <= sample_hold_ctrl;
        end
    end

    // sequencing state machine; a request outside idle starts nothing and is flagged only while holding
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (req_rise) begin
                        state_reg <= ST_FIRST;
                        cnt_reg   <= CNT_W'(PASS_CNT);
                    end
                end
                ST_FIRST: begin
                    if (cnt_reg == '0) begin
                        state_reg <= ST_CLEAR1;
                        cnt_reg   <= CNT_W'(CLEAR_CNT);
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_CLEAR1: begin
                    if (go_second) begin
                        state_reg <= ST_SECOND;
                        cnt_reg   <= CNT_W'(PASS_CNT);
                    end else if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_SECOND: begin
                    if (cnt_reg == '0) begin
                        state_reg <= ST_CLEAR2;
                        cnt_reg   <= CNT_W'(CLEAR_CNT);
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_CLEAR2: begin
                    // slave ends its cycle when the master reports done
                    if (is_master ? (cnt_reg == '0) : pdone_s) begin
                        state_reg <= ST_WAITRQ;
                    end else if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_WAITRQ: begin
                    if (!dreq_n_s) begin
                        state_reg <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (bit_reg == BIT_CNT_W'(RESULT_BITS - 1)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // process switch and converter controls from the current pass
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sample_hold_ctrl       <= 1'b0;
            pass_select            <= 1'b0;
            converter_clear_select <= 1'b1;
            local_convert_cmd      <= 1'b0;
            done_out               <= 1'b0;
        end else begin
            sample_hold_ctrl       <= (state_reg == ST_FIRST) ||
                                      (state_reg == ST_CLEAR1) ||
                                      (state_reg == ST_SECOND);
            pass_select            <= (state_reg == ST_FIRST);
            converter_clear_select <= (state_reg != ST_SECOND);
            local_convert_cmd      <= is_master &&
                                      ((state_reg == ST_FIRST) || (state_reg == ST_SECOND)) &&
                                      (cnt_reg == CNT_W'(PASS_CNT));
            done_out               <= is_master && (state_reg == ST_WAITRQ);
        end
    end

    // capture coarse then fine word; fine scaled down by 3 bits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result_reg <= '0;
        end else if (state_reg == ST_FIRST && cnt_reg == '0) begin
            result_reg <= {pass_word, 5'h00};
        end else if (state_reg == ST_SECOND && cnt_reg == '0) begin
            result_reg <= result_reg + RESULT_BITS'(pass_word[7:3]);
        end else if (state_reg == ST_SEND) begin
            result_reg <= {result_reg[RESULT_BITS-2:0], 1'b0};
        end
    end

    // serial result, msb first, one bit a cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_reg      <= '0;
            result_data  <= 1'b0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= (state_reg == ST_SEND);
            result_data  <= result_reg[RESULT_BITS-1];
            bit_reg      <= (state_reg == ST_SEND) ? bit_reg + 1'b1 : '0;
        end
    end

    property p_missed;
        @(posedge clk) disable iff (!rst_b)
        (req_rise && sample_hold_ctrl) |=> missed_sample_flag;
    endproperty
    a_missed: assert property (p_missed) else $error("missed sample not flagged");

    property p_oe;
        @(posedge clk) disable iff (!rst_b)
        shared_drive_oe_n == role_line_out;
    endproperty
    a_oe: assert property (p_oe) else $error("buffer enable wrong for role");

    property p_role;
        @(posedge clk) disable iff (!rst_b)
        ##1 (role_line_out == ~$past(role_s));
    endproperty
    a_role: assert property (p_role) else $error("role line not inverted");

    property p_sel;
        @(posedge clk) disable iff (!rst_b)
        pass_select |-> converter_clear_select;
    endproperty
    a_sel: assert property (p_sel) else $error("first pass without clear high");

    property p_hold;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == ST_IDLE && req_rise) |-> ##2 sample_hold_ctrl;
    endproperty
    a_hold: assert property (p_hold) else $error("request did not hold");

    property p_clear;
        @(posedge clk) disable iff (!rst_b)
        $fell(pass_select) |-> converter_clear_select;
    endproperty
    a_clear: assert property (p_clear) else $error("no reference between passes");

    property p_send;
        @(posedge clk) disable iff (!rst_b)
        $rose(result_valid) |-> $past(!dreq_n_s, 2);
    endproperty
    a_send: assert property (p_send) else $error("sent without filter request");

    property p_start;
        @(posedge clk) disable iff (!rst_b)
        local_convert_cmd |-> $past(is_master);
    endproperty
    a_start: assert property (p_start) else $error("slave issued convert");
endmodule
`default_nettype wire

// [include/adc_seq_pkg.sv]
// Purpose: shared constants and types for the two-pass converter sequencer
// Assumes: one 20 MHz clock, single converter board controller per instance
// Notes:   pass timing counts are in clock cycles at 50 ns
package adc_seq_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 50;
    // conversion time of the converter ic per pass, least value
    localparam int unsigned PASS_TIME_NS    = 1000;
    localparam int unsigned PASS_CYCLES     = (PASS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset-reference dwell between the passes, least value
    localparam int unsigned CLEAR_TIME_NS   = 500;
    localparam int unsigned CLEAR_CYCLES    = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESULT_BITS     = 13;
    localparam int unsigned CNT_W           = 8;
    localparam int unsigned BIT_CNT_W       = 4;

    // gray-coded along first, clear, second, send
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_FIRST  = 3'b001,
        ST_CLEAR1 = 3'b011,
        ST_SECOND = 3'b010,
        ST_CLEAR2 = 3'b110,
        ST_WAITRQ = 3'b111,
        ST_SEND   = 3'b101
    } seq_state_t;
endpackage

// [hdl/adc_sync2.sv]
// Purpose: two flip-flop level synchroniser
// Assumes: input is asynchronous to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module adc_sync2 (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_reg;

    // reset value low; pins idle low between conversions, except the filter request and the pulled-up role line, which idle high
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// [sim/peer_filter_model.sv]
// Purpose: far side of the sequencer: peer master board and digital filter controller
// Assumes: peer lines idle low, filter request idle high
// Notes:   slow stretches the filter response to stall the sender
`timescale 1ns/1ps
`default_nettype none
module peer_filter_model (
    input  wire logic clk,
    input  wire logic convert_request,
    input  wire logic done_out,
    input  wire logic result_valid,
    input  wire logic slave_mode,
    input  wire logic slow,
    output logic      filter_data_request_n,
    output logic      peer_done_in,
    output logic      peer_pass_select_in,
    output logic      req_low_seen
);
    // one conversion per loop; the peer plays master only when this board is slave
    always begin
        filter_data_request_n <= 1'b1;
        peer_done_in          <= 1'b0;
        peer_pass_select_in   <= 1'b0;
        req_low_seen          <= 1'b0;
        @(posedge convert_request);
        if (slave_mode) begin
            repeat (3) @(posedge clk);
            peer_pass_select_in <= 1'b1;
            repeat (8) @(posedge clk);
            peer_pass_select_in <= 1'b0;
            repeat (8) @(posedge clk);
            peer_done_in <= 1'b1;
        end
        wait (done_out || peer_done_in);
        // a slow filter leaves the finished result waiting
        repeat (slow ? 25 : 1) @(posedge clk);
        filter_data_request_n <= 1'b0;
        req_low_seen          <= 1'b1;
        wait (result_valid);
        wait (!result_valid);
        @(posedge clk);
    end
endmodule
`default_nettype wire

// [sim/tb.sv]
// Purpose: self-checking bench for the two-pass conversion sequencer
// Assumes: short pass counts; pass words driven by the bench
// Notes:   master runs first, then a second reset puts the board in slave role
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adc_seq_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, convert_request = 1'b0, role_line_in = 1'b1;
    logic        serial_config_data = 1'b0, slow = 1'b0, slave_mode = 1'b0;
    logic [7:0]  pass_word = 8'h00;
    logic        filter_data_request_n, peer_done_in, peer_pass_select_in, req_low_seen;
    logic        role_line_out, shared_drive_oe_n, sample_hold_ctrl, pass_select;
    logic        converter_clear_select, local_convert_cmd, done_out, missed_sample_flag;
    logic        result_data, result_valid, config_bit;
    logic [31:0] seed = 32'h0001_6A22;
    logic [31:0] v;
    int          err_total = 0, checked = 0, pulses = 0, i;
    int          exp_q[$];

    always #25 clk = ~clk;
    // count convert pulses of the current conversion
    always @(negedge clk) if (local_convert_cmd === 1'b1) pulses++;

    adc_sequencer #(.PASS_CNT(4), .CLEAR_CNT(3)) dut (
        .clk, .rst_b, .convert_request, .role_line_in, .peer_done_in, .peer_pass_select_in,
        .filter_data_request_n, .serial_config_data, .pass_word, .role_line_out,
        .shared_drive_oe_n, .sample_hold_ctrl, .pass_select, .converter_clear_select,
        .local_convert_cmd, .done_out, .missed_sample_flag, .result_data, .result_valid,
        .config_bit);
    peer_filter_model partner (.clk, .convert_request, .done_out, .result_valid,
        .slave_mode, .slow, .filter_data_request_n, .peer_done_in, .peer_pass_select_in,
        .req_low_seen);

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task wrap_up();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    function logic sig(input int k);
        case (k)
            0: sig = sample_hold_ctrl;
            1: sig = pass_select;
            2: sig = done_out;
            default: sig = result_valid;
        endcase
    endfunction

    // bounded wait on a design output; running out ends the run
    task wait_sig(input int k, input logic val);
        int n;
        n = 0;
        while (sig(k) !== val && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) begin
            err_total++;
            $display("unexpected at %0t: wait ran out", $time);
            wrap_up();
        end
    endtask

    // one conversion; model result is first word scaled plus reduced second word
    task convert_once(input logic [7:0] w1, input logic [7:0] w2, input bit miss,
                      input bit master);
        int b;
        logic [12:0] got;
        exp_q.push_back((int'(w1) * 32 + int'(w2) / 8) % 8192);
        @(negedge clk);
        pulses = 0;
        pass_word = w1;
        convert_request = 1'b1;
        if (master) begin
            wait_sig(0, 1'b1);
            chk(pass_select, 1'b1);
            if (miss) begin
                @(negedge clk) convert_request = 1'b0;
                @(negedge clk) convert_request = 1'b1;
            end
            wait_sig(1, 1'b0);
            chk(sample_hold_ctrl, 1'b1);
            chk(converter_clear_select, 1'b1);
            pass_word = w2;
            wait_sig(2, 1'b1);
            chk(result_valid, 1'b0);
        end
        wait_sig(3, 1'b1);
        chk(req_low_seen, 1'b1);
        got = '0;
        for (b = 0; b < 13; b++) begin
            got = {got[11:0], result_data};
            chk(result_valid, 1'b1);
            @(negedge clk);
        end
        chk(result_valid, 1'b0);
        chk(got, 16'(exp_q.pop_front()));
        chk(missed_sample_flag, miss);
        chk(16'(pulses), master ? 16'h0002 : 16'h0000);
        convert_request = 1'b0;
        repeat (4) @(negedge clk);
        chk(sample_hold_ctrl, 1'b0);
    endtask

    // hang guard
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        $display("unexpected at %0t: run too long", $time);
        wrap_up();
    end

    initial begin
        repeat (20) @(negedge clk);
        chk({role_line_out, shared_drive_oe_n, converter_clear_select, sample_hold_ctrl,
             pass_select, local_convert_cmd, done_out, missed_sample_flag, result_valid},
            16'h01C0);
        rst_b = 1'b1;
        repeat (5) @(negedge clk);
        chk({role_line_out, shared_drive_oe_n}, 16'h0000);
        for (i = 0; i < 4; i++) begin
            v = rnd();
            serial_config_data = v[0];
            repeat (4) @(negedge clk);
            chk(config_bit, v[0]);
        end
        for (i = 0; i < 8; i++) begin
            v = rnd();
            slow = i[0];
            convert_once(v[7:0], v[15:8], i[1], 1'b1);
        end
        convert_once(8'hFF, 8'hFF, 1'b0, 1'b1);
        convert_once(8'h00, 8'h07, 1'b1, 1'b1);
        // second reset in mid-run with the peer board strapped as master
        rst_b = 1'b0;
        role_line_in = 1'b0;
        slave_mode = 1'b1;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        repeat (5) @(negedge clk);
        chk({role_line_out, shared_drive_oe_n}, 16'h0003);
        for (i = 0; i < 3; i++) begin
            v = rnd();
            slow = i[0];
            convert_once(v[7:0], v[7:0], 1'b0, 1'b0);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
